// ==== rtl/dcs_pkg.sv ====
package dcs_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned PSET_WORDS       = 8;
  localparam logic [7:0]  OFS_OPT          = 8'h00;
  localparam logic [7:0]  OFS_PSET_LAST    = 8'h1c;
  localparam logic [7:0]  OFS_CE_LO        = 8'h40;
  localparam logic [7:0]  OFS_CE_HI        = 8'h44;
  localparam logic [7:0]  OFS_CE_CLR_LO    = 8'h48;
  localparam logic [7:0]  OFS_CE_CLR_HI    = 8'h4c;
  localparam logic [7:0]  OFS_IRQ_PEND_LO  = 8'h50;
  localparam logic [7:0]  OFS_IRQ_PEND_HI  = 8'h54;
  localparam logic [7:0]  OFS_IRQ_CLR_LO   = 8'h58;
  localparam logic [7:0]  OFS_IRQ_CLR_HI   = 8'h5c;
  localparam logic [7:0]  OFS_IRQ_EN_LO    = 8'h60;
  localparam logic [7:0]  OFS_IRQ_EN_HI    = 8'h64;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [31:0] OPT_WR_MASK      = 32'h00fb_ff0f;
  localparam logic [31:0] OPT_RESET        = 32'h0000_0000;
  localparam logic [31:0] WORD_RESET       = 32'h0000_0000;
  localparam logic [63:0] EVT_RESET        = 64'h0000_0000_0000_0000;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  reserved_top;
    logic [3:0]  owner_privilege_id;
    logic        mid_chain_enable;
    logic        final_chain_enable;
    logic        mid_irq_enable;
    logic        final_irq_enable;
    logic        reserved_write_zero;
    logic        reserved_read_zero;
    logic [5:0]  completion_code;
    logic        completion_point_select;
    logic [10:0] transfer_shape;
  } dcs_opt_t;

  typedef struct packed {
    logic valid;
    logic last;
  } dcs_tr_evt_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [63:0] dcs_code_onehot(input logic [5:0] code);
    dcs_code_onehot = 64'h1 << code;
  endfunction : dcs_code_onehot

  function automatic logic [31:0] dcs_strb_mask(input logic [3:0] strb);
    dcs_strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction : dcs_strb_mask

  function automatic logic [31:0] dcs_merge(input logic [31:0] old_word,
                                            input logic [31:0] new_word,
                                            input logic [3:0]  strb);
    logic [31:0] m;
    m = dcs_strb_mask(strb);
    dcs_merge = (old_word & ~m) | (new_word & m);
  endfunction : dcs_merge

endpackage : dcs_pkg

// ==== rtl/dcs_event_bits.sv ====
`timescale 1ns/10ps
module dcs_event_bits
  import dcs_pkg::*;
#(
  parameter int unsigned WIDTH = 64
) (
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             ce_in,
  input  wire logic [WIDTH-1:0] set_in,
  input  wire logic [WIDTH-1:0] clr_in,
  output logic      [WIDTH-1:0] bits_out
);

  logic [WIDTH-1:0] bits_ff;
  logic [WIDTH-1:0] nxt_bits;

  initial begin
    if (WIDTH != 64) $error("dcs_event_bits: WIDTH must be 64");
  end

  // ----------------------------------------------------------------
  // Sticky bits, set beats clear
  // ----------------------------------------------------------------
  always_comb begin
    nxt_bits = (bits_ff & ~clr_in) | set_in;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      bits_ff <= EVT_RESET;
    end else if (ce_in) begin
      bits_ff <= nxt_bits;
    end
  end

  assign bits_out = bits_ff;

  a_set_beats_clear: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ce_in |=> ((bits_ff & $past(set_in)) == $past(set_in)))
    else $error("event bit set was lost");

endmodule : dcs_event_bits

// ==== rtl/dcs_completion_top.sv ====
// Operation
// - Parameter-set write loads writer's privilege into owner field
// - Mid chain enable chains after non-final requests
// - Final chain enable chains after last request
// - Mid irq enable sets pending after non-final
// - Final irq enable sets pending after last
// - Interrupt forwarded only where enable bit set
// - Completion code picks the bit to set
// - Point select 0: complete when data finished
// - Point select 1: complete on hand-off
// - Chained-event bit set triggers that channel
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
module dcs_completion_top
  import dcs_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic              clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              ce_in,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic              s_axi_awvalid_in,
  output logic                   s_axi_awready_out,
  input  wire logic [31:0]       s_axi_wdata_in,
  input  wire logic [3:0]        s_axi_wstrb_in,
  input  wire logic              s_axi_wvalid_in,
  output logic                   s_axi_wready_out,
  output logic [1:0]             s_axi_bresp_out,
  output logic                   s_axi_bvalid_out,
  input  wire logic              s_axi_bready_in,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic              s_axi_arvalid_in,
  output logic                   s_axi_arready_out,
  output logic [31:0]            s_axi_rdata_out,
  output logic [1:0]             s_axi_rresp_out,
  output logic                   s_axi_rvalid_out,
  input  wire logic              s_axi_rready_in,
  input  wire logic [3:0]        master_priv_id_in,
  input  wire dcs_tr_evt_t       tr_submit_in,
  input  wire dcs_tr_evt_t       tr_done_in,
  output dcs_opt_t               options_out,
  output logic [63:0]            chain_trigger_out,
  output logic                   irq_out
);

  initial begin
    if (ADDR_W < 8) $error("dcs_completion_top: ADDR_W must be at least 8");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic              aw_full_ff;
  logic              nxt_aw_full;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [ADDR_W-1:0] nxt_aw_addr;
  logic [3:0]        aw_priv_ff;
  logic [3:0]        nxt_aw_priv;
  logic              w_full_ff;
  logic              nxt_w_full;
  logic [31:0]       w_data_ff;
  logic [31:0]       nxt_w_data;
  logic [3:0]        w_strb_ff;
  logic [3:0]        nxt_w_strb;
  logic              bvalid_ff;
  logic              nxt_bvalid;
  logic [1:0]        bresp_ff;
  logic [1:0]        nxt_bresp;
  logic              rvalid_ff;
  logic              nxt_rvalid;
  logic [31:0]       rdata_ff;
  logic [31:0]       nxt_rdata;
  logic [1:0]        rresp_ff;
  logic [1:0]        nxt_rresp;
  logic [31:0]       pset_ff [PSET_WORDS];
  logic [31:0]       nxt_pset [PSET_WORDS];
  logic [63:0]       ien_ff;
  logic [63:0]       nxt_ien;
  logic [63:0]       chain_trig_ff;
  logic [63:0]       nxt_chain_trig;
  logic              irq_ff;
  logic              nxt_irq;

  // ----------------------------------------------------------------
  // Combinational helpers
  // ----------------------------------------------------------------
  dcs_opt_t          channel_options_word;
  dcs_opt_t          opt_w;
  dcs_tr_evt_t       evt;
  logic [63:0]       code_hot;
  logic              chain_hit;
  logic              irq_hit;
  logic [63:0]       cer_set;
  logic [63:0]       ipr_set;
  logic [63:0]       cer_clr;
  logic [63:0]       ipr_clr;
  logic [63:0]       cer_bits;
  logic [63:0]       ipr_bits;
  logic              aw_take;
  logic              w_take;
  logic              ar_take;
  logic              do_wr;
  logic              wr_pset;
  logic [7:0]        wofs;
  logic [7:0]        rofs;
  logic              w_in_map;
  logic              r_in_map;
  logic [31:0]       merged;
  logic [31:0]       wmask;

  assign channel_options_word = dcs_opt_t'(pset_ff[0]);

  // ----------------------------------------------------------------
  // Completion detection
  // ----------------------------------------------------------------
  always_comb begin
    evt       = channel_options_word.completion_point_select ? tr_submit_in : tr_done_in;
    code_hot  = dcs_code_onehot(channel_options_word.completion_code);
    chain_hit = evt.valid && (evt.last ? channel_options_word.final_chain_enable : channel_options_word.mid_chain_enable);
    irq_hit   = evt.valid && (evt.last ? channel_options_word.final_irq_enable : channel_options_word.mid_irq_enable);
    cer_set   = chain_hit ? code_hot : EVT_RESET;
    ipr_set   = irq_hit ? code_hot : EVT_RESET;
    nxt_chain_trig = cer_set;
    nxt_irq   = |(ipr_bits & ien_ff);
  end

  dcs_event_bits #(
    .WIDTH (64)
  ) u_chained_events (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .ce_in      (ce_in),
    .set_in     (cer_set),
    .clr_in     (cer_clr),
    .bits_out   (cer_bits)
  );

  dcs_event_bits #(
    .WIDTH (64)
  ) u_irq_pending (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .ce_in      (ce_in),
    .set_in     (ipr_set),
    .clr_in     (ipr_clr),
    .bits_out   (ipr_bits)
  );

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  assign s_axi_awready_out = ce_in && !aw_full_ff && !bvalid_ff;
  assign s_axi_wready_out  = ce_in && !w_full_ff && !bvalid_ff;
  assign aw_take  = s_axi_awvalid_in && s_axi_awready_out;
  assign w_take   = s_axi_wvalid_in && s_axi_wready_out;
  assign do_wr    = aw_full_ff && w_full_ff && !bvalid_ff;
  assign wofs     = {aw_addr_ff[7:2], 2'h0};
  assign w_in_map = (aw_addr_ff >> 8) == '0;
  assign wr_pset  = do_wr && w_in_map && (wofs <= OFS_PSET_LAST);

  always_comb begin
    nxt_aw_full = aw_full_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_aw_priv = aw_priv_ff;
    nxt_w_full  = w_full_ff;
    nxt_w_data  = w_data_ff;
    nxt_w_strb  = w_strb_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    nxt_pset    = pset_ff;
    nxt_ien     = ien_ff;
    cer_clr     = EVT_RESET;
    ipr_clr     = EVT_RESET;
    wmask       = w_data_ff & dcs_strb_mask(w_strb_ff);
    merged      = dcs_merge(pset_ff[aw_addr_ff[4:2]], w_data_ff, w_strb_ff);
    opt_w       = dcs_opt_t'(merged & OPT_WR_MASK);
    if (aw_take) begin
      nxt_aw_full = 1'b1;
      nxt_aw_addr = s_axi_awaddr_in;
      nxt_aw_priv = master_priv_id_in;
    end
    if (w_take) begin
      nxt_w_full = 1'b1;
      nxt_w_data = s_axi_wdata_in;
      nxt_w_strb = s_axi_wstrb_in;
    end
    if (bvalid_ff && s_axi_bready_in) begin
      nxt_bvalid = 1'b0;
    end
    if (do_wr) begin
      nxt_aw_full = 1'b0;
      nxt_w_full  = 1'b0;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = RESP_OKAY;
      if (wr_pset) begin
        if (wofs != OFS_OPT) begin
          nxt_pset[aw_addr_ff[4:2]] = merged;
        end else begin
          nxt_pset[0] = opt_w;
        end
        nxt_pset[0][27:24] = aw_priv_ff;
      end else if (!w_in_map) begin
        nxt_bresp = RESP_SLVERR;
      end else begin
        case (wofs)
          OFS_CE_LO, OFS_CE_HI, OFS_IRQ_PEND_LO, OFS_IRQ_PEND_HI: begin
            nxt_bresp = RESP_OKAY;
          end
          OFS_CE_CLR_LO: begin
            cer_clr[31:0] = wmask;
          end
          OFS_CE_CLR_HI: begin
            cer_clr[63:32] = wmask;
          end
          OFS_IRQ_CLR_LO: begin
            ipr_clr[31:0] = wmask;
          end
          OFS_IRQ_CLR_HI: begin
            ipr_clr[63:32] = wmask;
          end
          OFS_IRQ_EN_LO: begin
            nxt_ien[31:0] = dcs_merge(ien_ff[31:0], w_data_ff, w_strb_ff);
          end
          OFS_IRQ_EN_HI: begin
            nxt_ien[63:32] = dcs_merge(ien_ff[63:32], w_data_ff, w_strb_ff);
          end
          default: begin
            nxt_bresp = RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign s_axi_arready_out = ce_in && !rvalid_ff;
  assign ar_take  = s_axi_arvalid_in && s_axi_arready_out;
  assign rofs     = {s_axi_araddr_in[7:2], 2'h0};
  assign r_in_map = (s_axi_araddr_in >> 8) == '0;

  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (rvalid_ff && s_axi_rready_in) begin
      nxt_rvalid = 1'b0;
    end
    if (ar_take) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = RESP_OKAY;
      nxt_rdata  = WORD_RESET;
      if (!r_in_map) begin
        nxt_rresp = RESP_SLVERR;
      end else if (rofs <= OFS_PSET_LAST) begin
        nxt_rdata = pset_ff[s_axi_araddr_in[4:2]];
      end else begin
        case (rofs)
          OFS_CE_LO: begin
            nxt_rdata = cer_bits[31:0];
          end
          OFS_CE_HI: begin
            nxt_rdata = cer_bits[63:32];
          end
          OFS_IRQ_PEND_LO: begin
            nxt_rdata = ipr_bits[31:0];
          end
          OFS_IRQ_PEND_HI: begin
            nxt_rdata = ipr_bits[63:32];
          end
          OFS_IRQ_EN_LO: begin
            nxt_rdata = ien_ff[31:0];
          end
          OFS_IRQ_EN_HI: begin
            nxt_rdata = ien_ff[63:32];
          end
          OFS_CE_CLR_LO, OFS_CE_CLR_HI, OFS_IRQ_CLR_LO, OFS_IRQ_CLR_HI: begin
            nxt_rdata = WORD_RESET;
          end
          default: begin
            nxt_rresp = RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      aw_full_ff    <= 1'b0;
      aw_addr_ff    <= '0;
      aw_priv_ff    <= 4'h0;
      w_full_ff     <= 1'b0;
      w_data_ff     <= WORD_RESET;
      w_strb_ff     <= 4'h0;
      bvalid_ff     <= 1'b0;
      bresp_ff      <= RESP_OKAY;
      rvalid_ff     <= 1'b0;
      rdata_ff      <= WORD_RESET;
      rresp_ff      <= RESP_OKAY;
      ien_ff        <= EVT_RESET;
      chain_trig_ff <= EVT_RESET;
      irq_ff        <= 1'b0;
      pset_ff[0]    <= OPT_RESET;
      for (int i = 1; i < PSET_WORDS; i++) begin
        pset_ff[i] <= WORD_RESET;
      end
    end else if (ce_in) begin
      aw_full_ff    <= nxt_aw_full;
      aw_addr_ff    <= nxt_aw_addr;
      aw_priv_ff    <= nxt_aw_priv;
      w_full_ff     <= nxt_w_full;
      w_data_ff     <= nxt_w_data;
      w_strb_ff     <= nxt_w_strb;
      bvalid_ff     <= nxt_bvalid;
      bresp_ff      <= nxt_bresp;
      rvalid_ff     <= nxt_rvalid;
      rdata_ff      <= nxt_rdata;
      rresp_ff      <= nxt_rresp;
      ien_ff        <= nxt_ien;
      chain_trig_ff <= nxt_chain_trig;
      irq_ff        <= nxt_irq;
      pset_ff       <= nxt_pset;
    end
  end

  assign s_axi_bvalid_out  = bvalid_ff;
  assign s_axi_bresp_out   = bresp_ff;
  assign s_axi_rvalid_out  = rvalid_ff;
  assign s_axi_rdata_out   = rdata_ff;
  assign s_axi_rresp_out   = rresp_ff;
  assign options_out       = channel_options_word;
  assign chain_trigger_out = chain_trig_ff;
  assign irq_out           = irq_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_mid_evt;
    ce_in && evt.valid && !evt.last;
  endsequence

  sequence s_final_evt;
    ce_in && evt.valid && evt.last;
  endsequence

  sequence s_early_final;
    ce_in && channel_options_word.completion_point_select && tr_submit_in.valid && tr_submit_in.last && channel_options_word.final_chain_enable;
  endsequence

  a_owner_load: assert property (ce_in && wr_pset |=> channel_options_word.owner_privilege_id == $past(aw_priv_ff))
    else $error("owner privilege not loaded by parameter write");

  a_mid_chain_on: assert property (s_mid_evt and channel_options_word.mid_chain_enable
                                   |=> chain_trigger_out == $past(code_hot) ##0 cer_bits[$past(channel_options_word.completion_code)])
    else $error("intermediate chaining missed");

  a_mid_chain_off: assert property (s_mid_evt and !channel_options_word.mid_chain_enable |=> chain_trigger_out == 64'h0)
    else $error("intermediate chaining while disabled");

  a_final_chain: assert property (s_final_evt |=> (chain_trigger_out != 64'h0) == $past(channel_options_word.final_chain_enable))
    else $error("final chaining wrong");

  a_mid_irq: assert property (s_mid_evt and channel_options_word.mid_irq_enable |=> ipr_bits[$past(channel_options_word.completion_code)])
    else $error("intermediate pending bit not set");

  a_final_irq: assert property (s_final_evt and channel_options_word.final_irq_enable |=> ipr_bits[$past(channel_options_word.completion_code)])
    else $error("final pending bit not set");

  a_irq_gate: assert property (ce_in |=> irq_out == $past(|(ipr_bits & ien_ff)))
    else $error("interrupt output does not follow enabled pending bits");

  a_code_onehot: assert property (chain_trigger_out != 64'h0 |-> $onehot(chain_trigger_out))
    else $error("chain trigger not a single code bit");

  a_normal_point: assert property (ce_in && !channel_options_word.completion_point_select && !tr_done_in.valid
                                   |=> chain_trigger_out == 64'h0)
    else $error("normal completion fired without data finish");

  a_early_point: assert property (s_early_final |=> chain_trigger_out == $past(code_hot))
    else $error("early completion missed at hand-off");

  a_trigger_sets: assert property ((chain_trigger_out & ~cer_bits) == 64'h0)
    else $error("trigger without chained-event bit");

  a_high_read: assert property (ar_take && r_in_map && rofs == OFS_IRQ_PEND_HI
                                |=> s_axi_rdata_out == $past(ipr_bits[63:32]))
    else $error("high pending register read wrong");

endmodule : dcs_completion_top

// ==== bench/dcs_tc_model.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Transfer controller model: submit pulse, then done DELAY+1 cycles later
// ----------------------------------------------------------------
module dcs_tc_model
  import dcs_pkg::*;
#(
  parameter int unsigned DELAY = 40
) (
  input  wire logic  clk_in,
  input  wire logic  sys_rst_in,
  input  wire logic  go_in,
  input  wire logic  last_in,
  output dcs_tr_evt_t tr_submit_out,
  output dcs_tr_evt_t tr_done_out,
  output logic        busy_out
);
  logic [7:0] cnt_ff;
  logic       busy_ff;
  logic       last_ff;

  // Idle lines show the inverse of the last flag, never a stale copy
  always_ff @(posedge clk_in) begin
    tr_submit_out <= '{valid: 1'b0, last: ~last_ff};
    tr_done_out   <= '{valid: 1'b0, last: ~last_ff};
    if (sys_rst_in) begin
      busy_ff <= 1'b0;
      cnt_ff  <= 8'h00;
      last_ff <= 1'b0;
    end else if (go_in && !busy_ff) begin
      busy_ff       <= 1'b1;
      last_ff       <= last_in;
      cnt_ff        <= 8'(DELAY);
      tr_submit_out <= '{valid: 1'b1, last: last_in};
    end else if (busy_ff && cnt_ff == 8'h00) begin
      busy_ff     <= 1'b0;
      tr_done_out <= '{valid: 1'b1, last: last_ff};
    end else if (busy_ff) begin
      cnt_ff <= cnt_ff - 8'h01;
    end
  end

  assign busy_out = busy_ff;
endmodule : dcs_tc_model

// ==== bench/dcs_completion_signalling_bench.sv ====
`timescale 1ns/10ps
module dma_completion_signalling_bench;
  import dcs_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk, rst, ce, awv, wv, bq, arv, rq, go, lst, awr, wr_rdy, bv, arr, rv, irq, busy;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdat, d;
  logic [3:0]  priv;
  logic [1:0]  br, rr, r;
  logic [63:0] trig, seen, v, ec, ep;
  logic [11:0] t;
  dcs_opt_t    channel_options_word;
  dcs_tr_evt_t sub, done;
  int          error_cnt, cmp_count, i;
  // Enables[11:8], point select[7], last[6], code[5:0]
  localparam logic [11:0] TBL [9] = '{12'h805, 12'h865, 12'h47f, 12'h400, 12'h21f,
                                      12'h260, 12'h168, 12'hfcc, 12'ha21};

  dcs_completion_top u_dut (.clk_in(clk), .sys_rst_in(rst), .ce_in(ce),
    .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_rdy),
    .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(bq),
    .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rdat), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rq),
    .master_priv_id_in(priv), .tr_submit_in(sub), .tr_done_in(done),
    .options_out(channel_options_word), .chain_trigger_out(trig), .irq_out(irq));

  dcs_tc_model u_tc (.clk_in(clk), .sys_rst_in(rst), .go_in(go), .last_in(lst),
    .tr_submit_out(sub), .tr_done_out(done), .busy_out(busy));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Collects every trigger pulse since the last request
  always @(posedge clk) seen <= go ? 64'h0 : (seen | trig);

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic tmo(input int n);
    if (n >= 200) begin
      error_cnt++;
      stop_test();
    end
  endtask : tmo

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] resp);
    int   n;
    logic ha, hw, hb;
    awa  <= a;
    wd   <= dat;
    awv  <= 1'b1;
    wv   <= 1'b1;
    bq   <= 1'b1;
    hb   = 1'b0;
    resp = 2'h3;
    for (n = 0; n < 200 && !hb; n++) begin
      @(negedge clk);
      ha = awv & awr;
      hw = wv & wr_rdy;
      hb = bq & bv;
      if (hb) resp = br;
      @(posedge clk);
      if (ha) awv <= 1'b0;
      if (hw) wv <= 1'b0;
      if (hb) bq <= 1'b0;
    end
    tmo(hb ? 0 : n);
    @(posedge clk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] resp);
    int   n;
    logic ha, hb;
    ara  <= a;
    arv  <= 1'b1;
    rq   <= 1'b1;
    hb   = 1'b0;
    resp = 2'h3;
    for (n = 0; n < 200 && !hb; n++) begin
      @(negedge clk);
      ha = arv & arr;
      hb = rq & rv;
      if (hb) dat = rdat;
      if (hb) resp = rr;
      @(posedge clk);
      if (ha) arv <= 1'b0;
      if (hb) rq <= 1'b0;
    end
    tmo(hb ? 0 : n);
    @(posedge clk);
  endtask : axi_rd

  task automatic rd64(input logic [7:0] a, output logic [63:0] val);
    logic [31:0] lo, hi;
    logic [1:0]  rs;
    axi_rd(a, lo, rs);
    axi_rd(a + 8'h04, hi, rs);
    val = {hi, lo};
  endtask : rd64

  task automatic wr64(input logic [7:0] a, input logic [63:0] val);
    logic [1:0] rs;
    axi_wr(a, val[31:0], rs);
    axi_wr(a + 8'h04, val[63:32], rs);
  endtask : wr64

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst, ce, awv, wv, bq, arv, rq, go, lst} = 9'h180;
    {awa, ara, wd, priv, error_cnt, cmp_count} = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    axi_rd(8'h80, d, r);
    chk({r, d}, {RESP_SLVERR, 32'h0});
    axi_wr(8'h80, 32'h1, r);
    chk(r, RESP_SLVERR);
    priv <= 4'h9;
    axi_wr(OFS_OPT, 32'hfff7_ffff, r);
    axi_rd(OFS_OPT, d, r);
    chk(d, (32'hfff7_ffff & OPT_WR_MASK) | 32'h0900_0000);
    priv <= 4'h3;
    axi_wr(OFS_PSET_LAST, 32'h1234_5678, r);
    chk(channel_options_word, (32'hfff7_ffff & OPT_WR_MASK) | 32'h0300_0000);
    for (i = 0; i < 9; i++) begin
      t  = TBL[i];
      ec = ((t[11] & !t[6]) | (t[10] & t[6])) ? (64'h1 << t[5:0]) : 64'h0;
      ep = ((t[9] & !t[6]) | (t[8] & t[6])) ? (64'h1 << t[5:0]) : 64'h0;
      priv <= i[3:0];
      axi_wr(OFS_OPT, {8'h00, t[11:8], 2'b00, t[5:0], t[7], 11'h000}, r);
      axi_rd(OFS_OPT, d, r);
      chk(d, {4'h0, i[3:0], t[11:8], 2'b00, t[5:0], t[7], 11'h000});
      go  <= 1'b1;
      lst <= t[6];
      @(posedge clk);
      go <= 1'b0;
      repeat (4) @(posedge clk);
      rd64(OFS_CE_LO, v);
      chk(v, t[7] ? ec : 64'h0);
      rd64(OFS_IRQ_PEND_LO, v);
      chk(v, t[7] ? ep : 64'h0);
      for (int n = 0; n < 200 && busy; n++) @(posedge clk);
      if (busy) tmo(200);
      repeat (2) @(posedge clk);
      rd64(OFS_CE_LO, v);
      chk(v, ec);
      rd64(OFS_IRQ_PEND_LO, v);
      chk(v, ep);
      chk(seen, ec);
      chk(irq, 1'b0);
      wr64(OFS_IRQ_EN_LO, ep);
      repeat (3) @(posedge clk);
      chk(irq, |ep);
      wr64(OFS_IRQ_CLR_LO, {64{1'b1}});
      wr64(OFS_CE_CLR_LO, {64{1'b1}});
      repeat (3) @(posedge clk);
      chk(irq, 1'b0);
      rd64(OFS_CE_LO, v);
      chk(v, 64'h0);
      wr64(OFS_IRQ_EN_LO, 64'h0);
    end
    stop_test();
  end
endmodule : dma_completion_signalling_bench
